//--- fscr_pkg.sv
// Constants shared by the security-register, lock and reset command decoder.
// Assumes a 100 MHz system clock that oversamples the host serial clock.
package fscr_pkg;

   // Opcodes handled by this decoder.
   localparam logic [7:0] OP_SECREG_READ   = 8'h48;
   localparam logic [7:0] OP_LOCK          = 8'h36;
   localparam logic [7:0] OP_UNLOCK        = 8'h39;
   localparam logic [7:0] OP_LOCK_READ     = 8'h3D;
   localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7E;
   localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
   localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
   localparam logic [7:0] OP_RESET         = 8'h99;
   localparam logic [7:0] OP_SFDP_READ     = 8'h5A;

   // Field lengths in bits.
   localparam logic [5:0] OPCODE_BITS = 6'd8;
   localparam logic [5:0] ADDR3_BITS  = 6'd24;
   localparam logic [5:0] ADDR4_BITS  = 6'd32;
   localparam logic [5:0] DUMMY_BITS  = 6'd8;
   localparam logic [3:0] BYTE_BITS   = 4'd8;
   localparam logic [5:0] STEP_SINGLE = 6'd1;
   localparam logic [5:0] STEP_QUAD   = 6'd4;

   // Security register geometry: 4 KiB in 16 pages of 256 bytes.
   localparam int          SECREG_BYTES    = 4096;
   localparam int          SECREG_PAGES    = 16;
   localparam int          SECREG_PAGE_LSB = 8;
   localparam logic [11:0] SECREG_FIRST    = 12'h000;
   localparam logic [11:0] SECREG_LAST     = 12'hFFF;

   // Lock bit array: one bit per 64 KiB block.
   localparam int   LOCK_COUNT   = 2048;
   localparam int   LOCK_IDX_LSB = 16;
   localparam int   LOCK_IDX_W   = 11;
   localparam logic LOCK_RESET   = 1'b0;

   // Reset and fill values, and output-enable patterns.
   localparam logic [7:0] ERASED_BYTE      = 8'hFF;
   localparam logic [7:0] STATUS_DELIVERED = 8'h00;
   localparam logic [7:0] SFDP_FILL        = 8'hFF;
   localparam logic [3:0] OE_SINGLE        = 4'h2;
   localparam logic [3:0] OE_QUAD          = 4'hF;

   // Reset recovery interval; a least time, so the cycle count rounds up.
   localparam int          CLK_MHZ          = 100;
   localparam int          RST_RECOVERY_NS  = 20000;
   localparam logic [11:0] RST_RECOVERY_CYC =
      12'((RST_RECOVERY_NS * CLK_MHZ + 999) / 1000);

   // Synchroniser width: chip select, serial clock and four data lines.
   localparam int SYNC_W = 6;

   typedef enum logic [2:0] {
      ST_OPCODE,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_DONE,
      ST_IGNORE
   } fscr_state_t;

endpackage

//--- fscr_sync.sv
// Two-stage synchroniser for the serial pins.
// Assumes its inputs are asynchronous to clk; only the second stage is read.
module fscr_sync
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [fscr_pkg::SYNC_W-1:0] d,
   output logic      [fscr_pkg::SYNC_W-1:0] q
);
   import fscr_pkg::*;

   logic [SYNC_W-1:0] meta_q;

   // The first stage feeds the second stage and nothing else.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '1;
         q      <= '1;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

//--- fscr_top.sv
// Serial flash command decoder for security-register read, block locks,
// software reset and the discoverable-parameter read.
// Assumes the host serial clock is below a sixth of clk; quad mode and
// address mode inputs come from logic on clk.
// Overview of operation
// - Opcode 48H, address, dummy byte; sample rising.
// - Drive read data on falling serial edge.
// - Read address increments after every output byte.
// - Low twelve address bits wrap FFFH to 000H.
// - Addresses 24 bits, 32 in four-byte mode.
// - Opcode 36H plus address sets block lock.
// - Opcode 39H plus address clears block lock.
// - Opcode 3DH returns lock bit in LSB.
// - Lone opcode 7EH sets all lock bits.
// - Lone opcode 98H clears all lock bits.
// - Reset needs 66H frame then 99H frame.
// - Accepted reset aborts work, restores power-on state; lock bits keep their values.
// - Reset clears volatile status, latch, suspend, parameters; no read parameters are kept here.
// - Commands ignored during reset recovery interval.
// - No software reset in continuous mode; quad mode accepts it.
// - Opcode 5AH returns parameter table bytes; every byte here reads SFDP_FILL, FFH.
// - Delivered state: erased bytes FFH, status 00H.
// - Suspend flags set at once, held until resume.
module fscr_top
(
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   input  wire logic                            cs_n,
   input  wire logic                            sclk,
   input  wire logic [3:0]                      io_in,
   output logic      [3:0]                      io_out,
   output logic      [3:0]                      io_oe,
   input  wire logic                            quad_command_mode,
   input  wire logic                            four_byte_mode,
   input  wire logic                            continuous_read_mode,
   input  wire logic                            protect_scheme_select,
   input  wire logic [4:0]                      protect_level_bits,
   input  wire logic                            secreg_wr_en,
   input  wire logic [11:0]                     secreg_wr_addr,
   input  wire logic [7:0]                      secreg_wr_data,
   input  wire logic                            status_wr_en,
   input  wire logic [7:0]                      status_wr_data,
   input  wire logic                            write_enable_set,
   input  wire logic                            write_enable_clr,
   input  wire logic [1:0]                      suspend_enter,
   input  wire logic                            resume_accept,
   input  wire logic [31:0]                     check_addr,
   output logic                                 check_protected,
   output logic [7:0]                           volatile_status,
   output logic                                 write_enable_latch,
   output logic [1:0]                           suspend_flags,
   output logic                                 soft_reset,
   output logic                                 reset_busy
);
   import fscr_pkg::*;

   logic [SYNC_W-1:0]     sync_s;
   logic                  sclk_prev_q, cs_prev_q;
   logic                  sclk_rise, sclk_fall, cs_rise, cs_high;
   logic [3:0]            io_s;
   fscr_state_t           state_q;
   logic [5:0]            bit_cnt_q, cnt_next, step, addr_len;
   logic [31:0]           in_sr_q, sh_next, addr_q;
   logic [7:0]            op_q, cur_byte, out_sr_q;
   logic [3:0]            out_left_q, io_out_q, io_oe_q;
   logic [11:0]           rd_addr_q, cur_addr;
   logic                  first_q, armed_q, soft_reset_q, write_enable_q, check_q;
   logic                  done_end, reset_take, cmd_busy;
   logic                  do_lock, do_unlock, do_glock, do_gunlock;
   logic [LOCK_COUNT-1:0] lock_q;
   logic [SECREG_PAGES-1:0] page_valid_q;
   logic [7:0]            secreg_mem [SECREG_BYTES];
   logic [11:0]           busy_cnt_q;
   logic [7:0]            status_q;
   logic [1:0]            suspend_q;

   // Block index of an address in the lock array.
   function automatic logic [LOCK_IDX_W-1:0] lock_idx(input logic [31:0] a);
      lock_idx = a[LOCK_IDX_LSB +: LOCK_IDX_W];
   endfunction

   // Pin levels for the top bits of an output byte.
   function automatic logic [3:0] drive(input logic [7:0] b, input logic quad);
      drive = quad ? b[7:4] : {2'b00, b[7], 1'b0};
   endfunction

   // Phase that follows a complete opcode.
   function automatic fscr_state_t after_op(input logic [7:0] op);
      unique case (op)
         OP_SECREG_READ, OP_LOCK, OP_UNLOCK,
         OP_LOCK_READ, OP_SFDP_READ: after_op = ST_ADDR;
         OP_GLOBAL_LOCK, OP_GLOBAL_UNLOCK,
         OP_RESET_ENABLE, OP_RESET:  after_op = ST_DONE;
         default:                    after_op = ST_IGNORE;
      endcase
   endfunction

   // Every pin crosses two flip-flops before the decoder looks at it.
   fscr_sync u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({cs_n, sclk, io_in}),
      .q     (sync_s)
   );

   assign cs_high   = sync_s[5];
   assign io_s      = sync_s[3:0];
   assign sclk_rise = sync_s[4] & ~sclk_prev_q;
   assign sclk_fall = ~sync_s[4] & sclk_prev_q;
   assign cs_rise   = cs_high & ~cs_prev_q;

   // Previous levels for edge detection, taken from the synchronised copies.
   // They reset to the synchroniser's reset level so release shows no false rise;
   // the fall that follows as the clock settles low is masked by chip select.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_prev_q <= 1'b1;
         cs_prev_q   <= 1'b1;
      end
      else
      begin
         sclk_prev_q <= sync_s[4];
         cs_prev_q   <= cs_high;
      end
   end

   // Width of one bus beat and of the address field.
   assign step     = quad_command_mode ? STEP_QUAD : STEP_SINGLE;
   assign addr_len = four_byte_mode ? ADDR4_BITS : ADDR3_BITS;
   assign cnt_next = bit_cnt_q + step;
   assign sh_next  = quad_command_mode ? {in_sr_q[27:0], io_s}
                                       : {in_sr_q[30:0], io_s[0]};
   assign cmd_busy = busy_cnt_q != 12'h000;

   // Input shifting and phase tracking on rising serial edges.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q   <= ST_OPCODE;
         bit_cnt_q <= 6'd0;
         in_sr_q   <= 32'h0000_0000;
         op_q      <= 8'h00;
         addr_q    <= 32'h0000_0000;
      end
      else if (cs_high)
      begin
         state_q   <= ST_OPCODE;
         bit_cnt_q <= 6'd0;
      end
      else if (sclk_rise)
      begin
         in_sr_q   <= sh_next;
         bit_cnt_q <= cnt_next;
         unique case (state_q)
            ST_OPCODE:
               if (cnt_next == OPCODE_BITS)
               begin
                  op_q      <= sh_next[7:0];
                  bit_cnt_q <= 6'd0;
                  state_q   <= cmd_busy ? ST_IGNORE : after_op(sh_next[7:0]);
               end
            ST_ADDR:
               if (cnt_next == addr_len)
               begin
                  addr_q    <= four_byte_mode ? sh_next : {8'h00, sh_next[23:0]};
                  bit_cnt_q <= 6'd0;
                  if (op_q == OP_LOCK_READ)
                     state_q <= ST_DATA;
                  else if (op_q == OP_LOCK || op_q == OP_UNLOCK)
                     state_q <= ST_DONE;
                  else
                     state_q <= ST_DUMMY;
               end
            ST_DUMMY:
               if (cnt_next == DUMMY_BITS)
                  state_q <= ST_DATA;
            ST_DONE:   state_q <= ST_IGNORE; // Extra clocks void the command.
            ST_DATA:   state_q <= ST_DATA;
            ST_IGNORE: state_q <= ST_IGNORE;
         endcase
      end
   end

   // Byte to send next; unwritten security pages read as erased.
   assign cur_addr = first_q ? addr_q[11:0] : rd_addr_q;
   always_comb
   begin
      unique case (op_q)
         OP_SECREG_READ:
            cur_byte = page_valid_q[cur_addr[11:SECREG_PAGE_LSB]] ?
                       secreg_mem[cur_addr] : ERASED_BYTE;
         OP_LOCK_READ: cur_byte = {7'h00, lock_q[lock_idx(addr_q)]};
         default:      cur_byte = SFDP_FILL;
      endcase
   end

   // Output shifting on falling serial edges; the pointer steps per byte.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_sr_q   <= 8'h00;
         out_left_q <= 4'h0;
         first_q    <= 1'b1;
         rd_addr_q  <= SECREG_FIRST;
         io_out_q   <= 4'h0;
         io_oe_q    <= 4'h0;
      end
      else if (cs_high)
      begin
         out_left_q <= 4'h0;
         first_q    <= 1'b1;
         io_oe_q    <= 4'h0;
      end
      else if (sclk_fall && state_q == ST_DATA)
      begin
         io_oe_q <= quad_command_mode ? OE_QUAD : OE_SINGLE;
         if (out_left_q == 4'h0)
         begin
            io_out_q   <= drive(cur_byte, quad_command_mode);
            out_sr_q   <= cur_byte << step;
            out_left_q <= BYTE_BITS - step[3:0];
            rd_addr_q  <= cur_addr + 12'h001; // 12-bit wrap.
            first_q    <= 1'b0;
         end
         else
         begin
            io_out_q   <= drive(out_sr_q, quad_command_mode);
            out_sr_q   <= out_sr_q << step;
            out_left_q <= out_left_q - step[3:0];
         end
      end
   end

   assign io_out = io_out_q;
   assign io_oe  = io_oe_q;

   // Commands that act when chip select rises after an exact frame.
   assign done_end   = cs_rise && state_q == ST_DONE;
   assign do_lock    = done_end && op_q == OP_LOCK;
   assign do_unlock  = done_end && op_q == OP_UNLOCK;
   assign do_glock   = done_end && op_q == OP_GLOBAL_LOCK;
   assign do_gunlock = done_end && op_q == OP_GLOBAL_UNLOCK;
   assign reset_take = done_end && op_q == OP_RESET && armed_q && !continuous_read_mode;

   // Lock bits; global commands take precedence over the single-block ones.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_q <= {LOCK_COUNT{LOCK_RESET}};
      else if (do_glock)
         lock_q <= '1;
      else if (do_gunlock)
         lock_q <= '0;
      else if (do_lock)
         lock_q[lock_idx(addr_q)] <= 1'b1;
      else if (do_unlock)
         lock_q[lock_idx(addr_q)] <= 1'b0;
   end

   // Protection answer for the array engines, one cycle after the query.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         check_q <= 1'b0;
      else
         check_q <= protect_scheme_select ? (protect_level_bits != 5'h00)
                                          : lock_q[lock_idx(check_addr)];
   end

   assign check_protected = check_q;

   // Security register storage; it has no reset, so page flags mark content.
   always_ff @(posedge clk)
   begin
      if (secreg_wr_en)
         secreg_mem[secreg_wr_addr] <= secreg_wr_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         page_valid_q <= '0;
      else if (secreg_wr_en)
         page_valid_q[secreg_wr_addr[11:SECREG_PAGE_LSB]] <= 1'b1;
   end

   // Reset pairing: any frame other than an exact enable frame disarms.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         armed_q <= 1'b0;
      else if (cs_rise)
         armed_q <= done_end && op_q == OP_RESET_ENABLE;
   end

   // Accepted reset pulses once, then blocks commands for the recovery time.
   // In continuous read the pair is refused so a running stream survives.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         soft_reset_q <= 1'b0;
         busy_cnt_q   <= 12'h000;
      end
      else
      begin
         soft_reset_q <= reset_take;
         if (reset_take)
            busy_cnt_q <= RST_RECOVERY_CYC;
         else if (cmd_busy)
            busy_cnt_q <= busy_cnt_q - 12'h001;
      end
   end

   assign soft_reset = soft_reset_q;
   assign reset_busy = cmd_busy;

   // Volatile state; a new set in the clearing cycle wins over the clear.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_q       <= STATUS_DELIVERED;
         write_enable_q <= 1'b0;
         suspend_q      <= 2'b00;
      end
      else
      begin
         if (status_wr_en)
            status_q <= status_wr_data;
         else if (soft_reset_q)
            status_q <= STATUS_DELIVERED;
         if (write_enable_set)
            write_enable_q <= 1'b1;
         else if (write_enable_clr || soft_reset_q)
            write_enable_q <= 1'b0;
         suspend_q <= suspend_enter |
                      (suspend_q & ~{2{resume_accept | soft_reset_q}});
      end
   end

   assign volatile_status    = status_q;
   assign write_enable_latch = write_enable_q;
   assign suspend_flags      = suspend_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_arm_frame;
      done_end && op_q == OP_RESET_ENABLE;
   endsequence

   sequence s_reset_frame;
      done_end && op_q == OP_RESET && !continuous_read_mode;
   endsequence

   a_opcode_decode: assert property (state_q == ST_OPCODE && !cs_high && sclk_rise
      && cnt_next == OPCODE_BITS && sh_next[7:0] == OP_SECREG_READ && !cmd_busy
      |=> state_q == ST_ADDR)
      else $error("Read opcode did not start the address phase.");
   a_drive_fall: assert property ($changed(io_out_q) |-> $past(sclk_fall))
      else $error("Output data changed away from a falling serial edge.");
   a_addr_step: assert property (sclk_fall && state_q == ST_DATA && !cs_high
      && out_left_q == 4'h0 |=> rd_addr_q == $past(cur_addr) + 12'h001)
      else $error("Read pointer did not advance after a byte.");
   a_addr_wrap: assert property (sclk_fall && state_q == ST_DATA && !cs_high
      && out_left_q == 4'h0 && cur_addr == SECREG_LAST |=> rd_addr_q == SECREG_FIRST)
      else $error("Read pointer did not wrap to zero.");
   a_lock_set: assert property (do_lock && !do_glock
      |=> lock_q[lock_idx(addr_q)])
      else $error("Block lock bit not set.");
   a_lock_clear: assert property (do_unlock |=> !lock_q[lock_idx(addr_q)])
      else $error("Block lock bit not cleared.");
   a_global_lock: assert property (do_glock |=> &lock_q)
      else $error("Global lock left a bit clear.");
   a_global_unlock: assert property (do_gunlock |=> lock_q == '0)
      else $error("Global unlock left a bit set.");
   a_reset_pair: assert property (s_arm_frame ##[1:1000] s_reset_frame
      |=> soft_reset_q ##1 busy_cnt_q == RST_RECOVERY_CYC - 12'h001)
      else $error("Reset pair was not accepted.");
   a_reset_unarmed: assert property (soft_reset_q |-> $past(armed_q))
      else $error("Reset taken without an enable frame.");
   a_busy_ignore: assert property (cmd_busy && !cs_high && sclk_rise
      && state_q == ST_OPCODE && cnt_next == OPCODE_BITS |=> state_q == ST_IGNORE)
      else $error("Command decoded during reset recovery.");
   a_reset_clears: assert property (soft_reset_q && !write_enable_set
      && suspend_enter == 2'b00 |=> !write_enable_q && suspend_q == 2'b00)
      else $error("Reset did not clear volatile state.");
   a_suspend_hold: assert property (suspend_q != 2'b00 && !resume_accept
      && !soft_reset_q |=> (suspend_q & $past(suspend_q)) == $past(suspend_q))
      else $error("Suspend flag not held until resume.");
   a_suspend_set: assert property (suspend_enter != 2'b00
      |=> (suspend_q & $past(suspend_enter)) == $past(suspend_enter))
      else $error("Suspend flag not set at once.");

endmodule

//--- fscr_host.sv
// Host controller model that frames commands on the serial link of the decoder.
// Assumes the bench resolves the shared data lines and hands their level back on io_w.
module fscr_host
(
   output logic            cs_n,
   output logic            sclk,
   output logic [3:0]      host_d,
   input  wire logic [3:0] io_w
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam realtime HALF = 62.5;
   logic [7:0]         rd_q [$];

   // The serial clock stands low between frames, as a real host leaves it.
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      host_d = 4'h0;
   end

   // One frame: header MSB first, data set while sclk is low so the device
   // samples it on the rising edge, then nrd bytes read on rising edges.
   task automatic frame(input logic quad, input logic [47:0] hdr, input int nb,
                        input int nrd);
      int         w;
      logic [7:0] b;
      w = quad ? 4 : 1;
      b = 8'h00;
      rd_q.delete();
      cs_n = 1'b0;
      for (int i = nb; i > 0; i -= w)
      begin
         host_d = quad ? hdr[i-1 -: 4] : {~host_d[3:1], hdr[i-1]};
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      // Released lines toggle every clock so a stale value never reads as data.
      for (int k = 0; k < nrd; k++)
      begin
         for (int j = 0; j < 8; j += w)
         begin
            host_d = ~host_d;
            #HALF sclk = 1'b1;
            b = quad ? {b[3:0], io_w} : {b[6:0], io_w[1]};
            #HALF sclk = 1'b0;
         end
         rd_q.push_back(b);
      end
      #HALF cs_n = 1'b1;
      host_d = ~host_d;
      #150; // Busy and suspend flags are left to the bench to look at first.
   endtask
endmodule

//--- tb.sv
// Self-checking bench for the security-register, lock and reset decoder.
// Assumes fscr_host drives the link and the bench resolves the data lines.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fscr_pkg::*;

   logic        clk, rst_n, cs_n, sclk, quad, four, cont, sel, swe, stwe, wels, welc, resm;
   logic        prot, latch, srst, busy;
   logic [3:0]  host_d, io_out, io_oe, io_w;
   logic [4:0]  lvl;
   logic [11:0] swa;
   logic [7:0]  swd, stwd, vstat, mem [0:4095];
   logic [1:0]  susp_in, susp;
   logic [31:0] caddr, a;
   int          errors, n_tests, n_soft;

   // Each line carries whichever party enables it; the host fills the rest.
   assign io_w = (io_oe & io_out) | (~io_oe & host_d);

   fscr_host fscr_host_inst (.cs_n(cs_n), .sclk(sclk), .host_d(host_d), .io_w(io_w));

   fscr_top fscr_top_inst
   (
      .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .io_in(io_w),
      .io_out(io_out), .io_oe(io_oe), .quad_command_mode(quad),
      .four_byte_mode(four), .continuous_read_mode(cont),
      .protect_scheme_select(sel), .protect_level_bits(lvl),
      .secreg_wr_en(swe), .secreg_wr_addr(swa), .secreg_wr_data(swd),
      .status_wr_en(stwe), .status_wr_data(stwd),
      .write_enable_set(wels), .write_enable_clr(welc),
      .suspend_enter(susp_in), .resume_accept(resm), .check_addr(caddr),
      .check_protected(prot), .volatile_status(vstat), .write_enable_latch(latch),
      .suspend_flags(susp), .soft_reset(srst), .reset_busy(busy)
   );

   // Free-running 100 MHz system clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Counts accepted reset pairs as seen on the one-cycle pulse.
   always @(posedge clk) if (srst === 1'b1) n_soft <= n_soft + 1;

   task automatic stop_test();
      if (errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   // Builds the header from the current address mode and hands it to the host.
   task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input bit has_a,
                      input bit dum, input int nrd);
      logic [47:0] h;
      int          nb;
      h = {40'h0, op};
      nb = 8;
      if (has_a)
      begin
         h = four ? {h[15:0], ad} : {h[23:0], ad[23:0]};
         nb += four ? 32 : 24;
      end
      if (dum)
      begin
         h = {h[39:0], 8'h00};
         nb += 8;
      end
      fscr_host_inst.frame(quad, h, nb, nrd);
      @(posedge clk);
   endtask

   task automatic chk_prot(input logic [31:0] ad, input logic exp);
      caddr <= ad;
      repeat (3) @(posedge clk);
      #1 check("check_protected", {31'h0, prot}, {31'h0, exp});
      @(posedge clk);
   endtask

   // The recovery interval is bounded; a hang counts as a mismatch.
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000)
      begin
         errors++;
         stop_test();
      end
   endtask

   initial
   begin
      {rst_n, quad, four, cont, sel, swe, stwe, wels, welc, resm} = '0;
      {lvl, swa, swd, stwd, susp_in, caddr, a} = '0;
      errors = 0;
      n_tests = 0;
      n_soft = 0;
      foreach (mem[i]) mem[i] = 8'hFF;
      void'($urandom(32'h5168));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("volatile_status", vstat, STATUS_DELIVERED);
      // Random bytes across the top and bottom pages, then two reads that wrap and one of an unwritten page.
      for (int i = 0; i < 32; i++)
      begin
         swe <= 1'b1;
         swa <= 12'hFF0 + 12'(i);
         swd <= 8'($urandom);
         @(posedge clk);
         mem[swa] = swd;
      end
      swe <= 1'b0;
      for (int r = 0; r < 3; r++)
      begin
         quad <= (r == 1);
         four <= (r != 0);
         a = (r == 0) ? 32'hFFE : (r == 1) ? 32'hFFD : 32'h800;
         @(posedge clk);
         cmd(OP_SECREG_READ, a, 1, 1, 5);
         for (int k = 0; k < 5; k++)
            check("secreg byte", fscr_host_inst.rd_q[k], mem[12'(a + k)]);
      end
      cmd(OP_SFDP_READ, 32'h0, 1, 1, 2);
      check("param bytes", {fscr_host_inst.rd_q[0], fscr_host_inst.rd_q[1]}, 16'hFFFF);
      // Block locks in single 24-bit and quad 32-bit modes.
      for (int m = 0; m < 2; m++)
      begin
         quad <= m[0];
         four <= m[0];
         sel <= 1'b0;
         a = {$urandom} & (m ? 32'h07FF_0000 : 32'h00FF_0000);
         @(posedge clk);
         cmd(OP_LOCK, a, 1, 0, 0);
         chk_prot(a | 32'h1234, 1'b1);
         chk_prot(a ^ 32'h1_0000, 1'b0);
         cmd(OP_LOCK_READ, a, 1, 0, 2);
         check("lock read", {fscr_host_inst.rd_q[0], fscr_host_inst.rd_q[1]}, 16'h0101);
         cmd(OP_UNLOCK, a, 1, 0, 0);
         chk_prot(a, 1'b0);
         cmd(OP_GLOBAL_LOCK, 32'h0, 0, 0, 0);
         chk_prot($urandom, 1'b1);
         sel <= 1'b1;
         lvl <= 5'h00;
         chk_prot($urandom, 1'b0);
         lvl <= 5'($urandom_range(31, 1));
         chk_prot($urandom, 1'b1);
         sel <= 1'b0;
         cmd(OP_GLOBAL_UNLOCK, 32'h0, 0, 0, 0);
         chk_prot($urandom, 1'b0);
      end
      // Resume and a new suspend in one cycle: the new set wins, as for the latch.
      susp_in <= 2'b01;
      @(posedge clk);
      {susp_in, resm, wels, welc} <= 5'b10111;
      @(posedge clk);
      {susp_in, resm, wels, welc} <= '0;
      #1 check("suspend_flags", susp, 2'b10);
      check("write_enable_latch", latch, 1'b1);
      @(posedge clk);
      {resm, welc} <= 2'b11;
      @(posedge clk);
      {resm, welc} <= 2'b00;
      #1 check("resumed flags", {latch, susp}, 3'h0);
      // Volatile state set up, then the reset pair refused and accepted.
      quad <= 1'b0;
      four <= 1'b0;
      stwe <= 1'b1;
      stwd <= 8'($urandom) | 8'h01;
      wels <= 1'b1;
      susp_in <= 2'b11;
      @(posedge clk);
      {stwe, wels, susp_in} <= '0;
      #1 check("suspend_flags", susp, 2'b11);
      check("write_enable_latch", latch, 1'b1);
      cont <= 1'b1;
      @(posedge clk);
      cmd(OP_RESET_ENABLE, 32'h0, 0, 0, 0);
      cmd(OP_RESET, 32'h0, 0, 0, 0);
      check("refused resets", n_soft, 0);
      check("volatile_status", vstat, stwd);
      cont <= 1'b0;
      @(posedge clk);
      cmd(OP_RESET_ENABLE, 32'h0, 0, 0, 0);
      cmd(OP_RESET, 32'h0, 0, 0, 0);
      check("accepted resets", n_soft, 1);
      check("cleared state", {vstat, latch, susp}, 11'h0);
      check("reset_busy", busy, 1'b1);
      cmd(OP_GLOBAL_LOCK, 32'h0, 0, 0, 0);
      wait_idle();
      chk_prot($urandom, 1'b0);
      // Recovery from quad mode: idle-high clocks, the quad pair, then the single pair.
      quad <= 1'b1;
      @(posedge clk);
      check("suspend_flags", susp, 2'b00);
      fscr_host_inst.frame(1'b1, '1, 32, 0);
      cmd(OP_RESET_ENABLE, 32'h0, 0, 0, 0);
      cmd(OP_RESET, 32'h0, 0, 0, 0);
      check("quad resets", n_soft, 2);
      wait_idle();
      quad <= 1'b0;
      @(posedge clk);
      cmd(OP_RESET_ENABLE, 32'h0, 0, 0, 0);
      cmd(OP_RESET, 32'h0, 0, 0, 0);
      check("single resets", n_soft, 3);
      wait_idle();
      stop_test();
   end
endmodule
